// File: hw/vtp_fifo.sv
// pixel buffer with registered output stage and back-pressure
`timescale 1ns/1ps
`default_nettype none
module vtp_fifo #(
   parameter int WIDTH = 26,
   parameter int DEPTH = 16
) (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wptr_q;
   logic [AW-1:0] rptr_q;
   logic [CW-1:0] count_q;
   logic push;
   logic load;

   // full only when every memory word holds data
   assign o_in_ready = (count_q != FULL_COUNT);
   assign push = i_in_valid && o_in_ready;
   assign load = (count_q != '0) && (!o_out_valid || i_out_ready);

   // storage write
   always_ff @(posedge i_clock) begin
      if (push) begin
         mem[wptr_q] <= i_in_data;
      end
   end

   // pointers and occupancy
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wptr_q <= '0;
         rptr_q <= '0;
         count_q <= '0;
      end else begin
         if (push) begin
            wptr_q <= AW'(wptr_q + 1'b1);
         end
         if (load) begin
            rptr_q <= AW'(rptr_q + 1'b1);
         end
         count_q <= CW'(count_q + CW'(push) - CW'(load));
      end
   end

   // output register, held while the sink stalls
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_out_valid <= 1'b0;
         o_out_data <= '0;
      end else if (load) begin
         o_out_valid <= 1'b1;
         o_out_data <= mem[rptr_q];
      end else if (i_out_ready) begin
         o_out_valid <= 1'b0;
      end
   end
endmodule : vtp_fifo
`default_nettype wire

// File: hw/vtp_pkg.sv
// shared constants and types of the video test pattern selector
package vtp_pkg;
   // register word indices; byte address is four times the index
   localparam logic [7:0] IDX_LOOP_THROUGH = 8'h63;
   localparam logic [7:0] IDX_CONTROL = 8'h64;
   localparam logic [7:0] IDX_CONFIG = 8'h65;
   localparam logic [7:0] IDX_CUSTOM_RED = 8'h70;
   localparam logic [7:0] IDX_CUSTOM_GREEN = 8'h71;
   localparam logic [7:0] IDX_CUSTOM_BLUE = 8'h72;
   localparam logic [7:0] IDX_FRAME_TIME = 8'h73;
   localparam logic [7:0] IDX_STATUS = 8'h74;

   // reset values
   localparam logic [7:0] RST_CONTROL = 8'h10;
   localparam logic [4:0] RST_CONFIG = 5'h00;
   localparam logic [7:0] RST_CUSTOM = 8'h00;
   localparam logic [7:0] RST_FRAME_TIME = 8'h01;
   localparam logic [3:0] RST_SCROLL = 4'h1;

   // field positions of the configuration register
   localparam int CFG_AUTO_SCROLL_BIT = 0;
   localparam int CFG_INVERT_BIT = 1;

   // selector codes
   localparam logic [3:0] SEL_SOLID_FIRST = 4'h1;
   localparam logic [3:0] SEL_SOLID_LAST = 4'h5;
   localparam logic [3:0] SEL_HRAMP_FIRST = 4'h6;
   localparam logic [3:0] SEL_HRAMP_LAST = 4'h9;
   localparam logic [3:0] SEL_VRAMP_FIRST = 4'hA;
   localparam logic [3:0] SEL_VRAMP_LAST = 4'hD;
   localparam logic [3:0] SEL_CUSTOM = 4'hE;

   // active frame geometry of the internal raster
   localparam int H_ACTIVE = 64;
   localparam int V_ACTIVE = 32;
   localparam logic [8:0] H_SPAN = 9'h040;
   localparam logic [8:0] V_SPAN = 9'h020;
   localparam logic [7:0] H_LAST = 8'h3F;
   localparam logic [7:0] V_LAST = 8'h1F;

   // pixel buffer shape
   localparam int FIFO_DEPTH = 16;

   // control register layout
   typedef struct packed {
      logic [3:0] fixed_pattern_selector;
      logic compliance_pattern_enable;
      logic color_bars_enable;
      logic vcom_band_order_reverse;
      logic generator_enable;
   } vtp_ctrl_s;

   // one pixel of the stream with its frame markers
   typedef struct packed {
      logic sof;
      logic eol;
      logic [7:0] red;
      logic [7:0] green;
      logic [7:0] blue;
   } vtp_pix_s;

   localparam int PIX_W = 26;

   // pattern source after priority
   typedef enum logic [1:0] {
      MODE_FIXED = 2'b00,
      MODE_BARS = 2'b01,
      MODE_COMPLIANCE = 2'b10
   } vtp_mode_e;

   // raster generator state
   typedef enum logic {
      GEN_IDLE = 1'b0,
      GEN_RUN = 1'b1
   } vtp_gen_e;
endpackage : vtp_pkg

// File: hw/vtp_top.sv
// test pattern selector: apb registers, raster, pattern choice, buffer
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module vtp_top (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic o_pix_valid,
   input wire logic i_pix_ready,
   output vtp_pkg::vtp_pix_s o_pix_data,
   output logic o_loop_through_driver_powerdown
);
   vtp_pkg::vtp_ctrl_s ctrl_q;
   logic [4:0] cfg_q;
   logic [7:0] custom_red_level_q, custom_green_level_q, custom_blue_level_q;
   logic [7:0] frame_time_q, frame_cnt_q, x_q, y_q;
   logic [3:0] scroll_sel_q, eff_sel;
   vtp_pkg::vtp_gen_e gen_q;
   logic access, wr_en, hit;
   logic [7:0] idx, rd_val, h_level, v_level;
   logic auto_scroll_enable, color_invert_select;
   vtp_pkg::vtp_mode_e mode;
   logic gen_valid, fifo_ready, accept, frame_end, scroll_due;
   logic [23:0] rgb;
   vtp_pkg::vtp_pix_s gen_pix, fifo_out;
   // brightness at a position, evenly spread across the span
   function automatic logic [7:0] ramp_level(input logic [7:0] pos,
                                             input logic [8:0] span);
      logic [15:0] q;
      q = 16'({pos, 8'h00} / {7'h00, span});
      return q[7:0];
   endfunction : ramp_level
   // expand an rgb on/off mask at a given level
   function automatic logic [23:0] paint(input logic [2:0] mask,
                                         input logic [7:0] lvl);
      return {mask[2] ? lvl : 8'h00, mask[1] ? lvl : 8'h00,
              mask[0] ? lvl : 8'h00};
   endfunction : paint
   // colour mask of a solid or ramp selector code
   function automatic logic [2:0] sel_mask(input logic [3:0] code);
      case (code)
         4'h1, 4'h6, 4'hA: return 3'h7;
         4'h3, 4'h7, 4'hB: return 3'h4;
         4'h4, 4'h8, 4'hC: return 3'h2;
         4'h5, 4'h9, 4'hD: return 3'h1;
         default: return 3'h0;
      endcase
   endfunction : sel_mask
   // next pattern in the scroll sequence, skipping reserved codes
   function automatic logic [3:0] next_code(input logic [3:0] code);
      if (code >= vtp_pkg::SEL_CUSTOM || code == 4'h0) begin
         return vtp_pkg::SEL_SOLID_FIRST;
      end
      return 4'(code + 4'h1);
   endfunction : next_code
   // apb decode; two-cycle access, effect at the edge with pready high
   assign access = i_psel && i_penable;
   assign wr_en = access && o_pready && i_pwrite;
   assign idx = i_paddr[9:2];
   assign hit = (i_paddr[11:10] == 2'b00) && (i_paddr[1:0] == 2'b00) &&
                ((idx == vtp_pkg::IDX_LOOP_THROUGH) ||
                 (idx >= vtp_pkg::IDX_CONTROL && idx <= vtp_pkg::IDX_CONFIG) ||
                 (idx >= vtp_pkg::IDX_CUSTOM_RED &&
                  idx <= vtp_pkg::IDX_STATUS));
   // read mux, reserved bits read zero
   always_comb begin
      rd_val = 8'h00;
      case (idx)
         vtp_pkg::IDX_LOOP_THROUGH: rd_val = {7'h00,
                                              o_loop_through_driver_powerdown};
         vtp_pkg::IDX_CONTROL: rd_val = ctrl_q;
         vtp_pkg::IDX_CONFIG: rd_val = {3'h0, cfg_q};
         vtp_pkg::IDX_CUSTOM_RED: rd_val = custom_red_level_q;
         vtp_pkg::IDX_CUSTOM_GREEN: rd_val = custom_green_level_q;
         vtp_pkg::IDX_CUSTOM_BLUE: rd_val = custom_blue_level_q;
         vtp_pkg::IDX_FRAME_TIME: rd_val = frame_time_q;
         vtp_pkg::IDX_STATUS: rd_val = {eff_sel, 1'b0, mode, gen_q};
         default: rd_val = 8'h00;
      endcase
   end
   // bus handshake and read data
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h0000_0000;
      end else if (access && !o_pready) begin
         o_pready <= 1'b1;
         o_pslverr <= !hit;
         o_prdata <= (hit && !i_pwrite) ? {24'h00_0000, rd_val} : 32'h0;
      end else begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
      end
   end
   // control register: selector, compliance, bars, vcom order, enable
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_q <= vtp_pkg::RST_CONTROL;
      end else if (wr_en && hit && idx == vtp_pkg::IDX_CONTROL) begin
         ctrl_q <= i_pwdata[7:0];
      end
   end
   // configuration, custom colour, frame time and loop-through registers
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cfg_q <= vtp_pkg::RST_CONFIG;
         custom_red_level_q <= vtp_pkg::RST_CUSTOM;
         custom_green_level_q <= vtp_pkg::RST_CUSTOM;
         custom_blue_level_q <= vtp_pkg::RST_CUSTOM;
         frame_time_q <= vtp_pkg::RST_FRAME_TIME;
         o_loop_through_driver_powerdown <= 1'b0;
      end else if (wr_en && hit) begin
         case (idx)
            vtp_pkg::IDX_CONFIG: cfg_q <= i_pwdata[4:0];
            vtp_pkg::IDX_CUSTOM_RED: custom_red_level_q <= i_pwdata[7:0];
            vtp_pkg::IDX_CUSTOM_GREEN: custom_green_level_q <= i_pwdata[7:0];
            vtp_pkg::IDX_CUSTOM_BLUE: custom_blue_level_q <= i_pwdata[7:0];
            vtp_pkg::IDX_FRAME_TIME: frame_time_q <= i_pwdata[7:0];
            vtp_pkg::IDX_LOOP_THROUGH: begin
               o_loop_through_driver_powerdown <= i_pwdata[0];
            end
            default: ;
         endcase
      end
   end
   assign auto_scroll_enable = cfg_q[vtp_pkg::CFG_AUTO_SCROLL_BIT];
   assign color_invert_select = cfg_q[vtp_pkg::CFG_INVERT_BIT];
   // raster runs only while enabled; buffer back-pressure stalls it
   assign gen_valid = (gen_q == vtp_pkg::GEN_RUN) && ctrl_q.generator_enable;
   assign accept = gen_valid && fifo_ready;
   assign frame_end = accept && x_q == vtp_pkg::H_LAST &&
                      y_q == vtp_pkg::V_LAST;
   // raster position, restarts at the top left when idle
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         gen_q <= vtp_pkg::GEN_IDLE;
         x_q <= 8'h00;
         y_q <= 8'h00;
      end else begin
         case (gen_q)
            vtp_pkg::GEN_IDLE: begin
               x_q <= 8'h00;
               y_q <= 8'h00;
               if (ctrl_q.generator_enable) begin
                  gen_q <= vtp_pkg::GEN_RUN;
               end
            end
            vtp_pkg::GEN_RUN: begin
               if (!ctrl_q.generator_enable) begin
                  gen_q <= vtp_pkg::GEN_IDLE;
               end else if (accept) begin
                  if (x_q == vtp_pkg::H_LAST) begin
                     x_q <= 8'h00;
                     y_q <= (y_q == vtp_pkg::V_LAST) ? 8'h00 : 8'(y_q + 8'h01);
                  end else begin
                     x_q <= 8'(x_q + 8'h01);
                  end
               end
            end
            default: gen_q <= vtp_pkg::GEN_IDLE;
         endcase
      end
   end
   // auto-scroll: frame count and pattern advance
   assign scroll_due = frame_end && ({1'b0, frame_cnt_q} + 9'h001 >=
                       {1'b0, (frame_time_q == 8'h00) ? 8'h01 : frame_time_q});

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         scroll_sel_q <= vtp_pkg::RST_SCROLL;
         frame_cnt_q <= 8'h00;
      end else if (!auto_scroll_enable) begin
         scroll_sel_q <= ctrl_q.fixed_pattern_selector;
         frame_cnt_q <= 8'h00;
      end else if (scroll_due) begin
         scroll_sel_q <= next_code(scroll_sel_q);
         frame_cnt_q <= 8'h00;
      end else if (frame_end) begin
         frame_cnt_q <= 8'(frame_cnt_q + 8'h01);
      end
   end
   // source priority and effective selector
   assign eff_sel = auto_scroll_enable ? scroll_sel_q :
                    ctrl_q.fixed_pattern_selector;
   assign mode = ctrl_q.compliance_pattern_enable ?
                 vtp_pkg::MODE_COMPLIANCE :
                 ctrl_q.color_bars_enable ? vtp_pkg::MODE_BARS :
                 vtp_pkg::MODE_FIXED;

   assign h_level = ramp_level(x_q, vtp_pkg::H_SPAN);
   assign v_level = ramp_level(y_q, vtp_pkg::V_SPAN);
   // pixel colour for the current raster position
   always_comb begin
      rgb = 24'h00_0000;
      case (mode)
         vtp_pkg::MODE_COMPLIANCE: begin
            case (h_level[7:6])
               2'd0: rgb = paint(ctrl_q.vcom_band_order_reverse ? 3'h1 : 3'h6,
                                 8'hFF);
               2'd1: rgb = paint(3'h3, 8'hFF);
               2'd2: rgb = paint(ctrl_q.vcom_band_order_reverse ? 3'h6 : 3'h1,
                                 8'hFF);
               default: rgb = paint(3'h4, 8'hFF);
            endcase
         end
         vtp_pkg::MODE_BARS: begin
            case (h_level[7:5])
               3'd0: rgb = paint(3'h7, 8'hFF);
               3'd1: rgb = paint(3'h6, 8'hFF);
               3'd2: rgb = paint(3'h3, 8'hFF);
               3'd3: rgb = paint(3'h2, 8'hFF);
               3'd4: rgb = paint(3'h5, 8'hFF);
               3'd5: rgb = paint(3'h4, 8'hFF);
               3'd6: rgb = paint(3'h1, 8'hFF);
               default: rgb = paint(3'h0, 8'hFF);
            endcase
         end
         default: begin
            if (eff_sel >= vtp_pkg::SEL_SOLID_FIRST &&
                eff_sel <= vtp_pkg::SEL_SOLID_LAST) begin
               rgb = paint(sel_mask(eff_sel), 8'hFF);
            end else if (eff_sel >= vtp_pkg::SEL_HRAMP_FIRST &&
                         eff_sel <= vtp_pkg::SEL_HRAMP_LAST) begin
               rgb = paint(sel_mask(eff_sel), h_level);
            end else if (eff_sel >= vtp_pkg::SEL_VRAMP_FIRST &&
                         eff_sel <= vtp_pkg::SEL_VRAMP_LAST) begin
               rgb = paint(sel_mask(eff_sel), v_level);
            end else if (eff_sel == vtp_pkg::SEL_CUSTOM) begin
               rgb = {custom_red_level_q, custom_green_level_q,
                      custom_blue_level_q};
            end
         end
      endcase
   end
   // inversion applies to every source
   assign gen_pix.sof = (x_q == 8'h00) && (y_q == 8'h00);
   assign gen_pix.eol = (x_q == vtp_pkg::H_LAST);
   assign {gen_pix.red, gen_pix.green, gen_pix.blue} =
          color_invert_select ? ~rgb : rgb;

   vtp_fifo #(
      .WIDTH(vtp_pkg::PIX_W),
      .DEPTH(vtp_pkg::FIFO_DEPTH)
   ) u_fifo (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_in_valid(gen_valid),
      .o_in_ready(fifo_ready),
      .i_in_data(gen_pix),
      .o_out_valid(o_pix_valid),
      .i_out_ready(i_pix_ready),
      .o_out_data(fifo_out)
   );
   assign o_pix_data = fifo_out;
   // checks
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);

   sequence s_wait;
      access && !o_pready;
   endsequence
   sequence s_ctrl_write;
      wr_en && hit && idx == vtp_pkg::IDX_CONTROL;
   endsequence

   AST_SEL_WRITE: assert property (s_ctrl_write |=>
      ctrl_q.fixed_pattern_selector == $past(i_pwdata[7:4]))
      else $error("selector not stored");
   AST_APB_READY: assert property (s_wait |=> o_pready ##1 !o_pready)
      else $error("apb ready timing wrong");
   AST_IDLE: assert property (!ctrl_q.generator_enable |-> !gen_valid ##1
      gen_q == vtp_pkg::GEN_IDLE)
      else $error("generator runs while disabled");
   AST_COMPLIANCE: assert property (ctrl_q.compliance_pattern_enable |->
      mode == vtp_pkg::MODE_COMPLIANCE)
      else $error("compliance not chosen");
   AST_BARS_PRIO: assert property (ctrl_q.color_bars_enable &&
      !ctrl_q.compliance_pattern_enable |-> mode == vtp_pkg::MODE_BARS)
      else $error("bars priority wrong");
   AST_BAR_FIRST: assert property (mode == vtp_pkg::MODE_BARS &&
      x_q == 8'h00 && !color_invert_select |-> rgb == 24'hFF_FFFF)
      else $error("first bar not white");
   AST_SOLID_RED: assert property (mode == vtp_pkg::MODE_FIXED &&
      eff_sel == 4'h3 |-> rgb == 24'hFF_0000)
      else $error("red solid wrong");
   AST_RAMP_END: assert property (mode == vtp_pkg::MODE_FIXED &&
      eff_sel == 4'h6 && x_q == vtp_pkg::H_LAST |-> rgb == 24'hFC_FCFC)
      else $error("ramp end level wrong");
   AST_VRAMP: assert property (mode == vtp_pkg::MODE_FIXED &&
      eff_sel == 4'hD |-> rgb[23:8] == 16'h0000 && rgb[7:0] == v_level)
      else $error("vertical blue ramp wrong");
   AST_CUSTOM: assert property (mode == vtp_pkg::MODE_FIXED &&
      eff_sel == vtp_pkg::SEL_CUSTOM |-> rgb[15:8] == custom_green_level_q)
      else $error("custom colour wrong");
   AST_VCOM_REV: assert property (mode == vtp_pkg::MODE_COMPLIANCE &&
      x_q == 8'h00 && ctrl_q.vcom_band_order_reverse |-> rgb == 24'h00_00FF)
      else $error("vcom order wrong");
   AST_INVERT: assert property (color_invert_select |->
      {gen_pix.red, gen_pix.green, gen_pix.blue} == ~rgb)
      else $error("inversion missing");
   AST_SCROLL_HOLD: assert property (auto_scroll_enable && !scroll_due
      |=> $stable(scroll_sel_q))
      else $error("scroll moved early");
   AST_SCROLL_SEL: assert property (auto_scroll_enable |->
      eff_sel == scroll_sel_q)
      else $error("selector not ignored in scroll");
endmodule : vtp_top
`default_nettype wire

// File: sim/vtp_top_tb.sv
// self-checking bench of the test pattern selector
`timescale 1ns/1ps
`default_nettype none
module vtp_top_tb;
   logic clk, rst_n, psel, penable, pwrite, pix_ready, pready, pslverr;
   logic pix_valid, pwdn, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   vtp_pkg::vtp_pix_s pix;
   logic [25:0] px [0:64];
   logic [23:0] sol [0:4] = '{24'hFFFFFF, 24'h000000, 24'hFF0000,
      24'h00FF00, 24'h0000FF};
   logic [23:0] bar [0:7] = '{24'hFFFFFF, 24'hFFFF00, 24'h00FFFF,
      24'h00FF00, 24'hFF00FF, 24'hFF0000, 24'h0000FF, 24'h000000};
   logic [23:0] vc [0:7] = '{24'hFFFF00, 24'h00FFFF, 24'h0000FF,
      24'hFF0000, 24'h0000FF, 24'h00FFFF, 24'hFFFF00, 24'hFF0000};
   int err_total = 0;
   int n_compared = 0;

   vtp_top i_dut (.i_clock(clk), .i_rst_n(rst_n), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .o_pix_valid(pix_valid), .i_pix_ready(pix_ready),
      .o_pix_data(pix), .o_loop_through_driver_powerdown(pwdn));

   // free-running clock, 100 ns period
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task finish_test;
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : finish_test

   task cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : cmp

   // one apb transfer; result left in rd and er
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      cmp(k < 20, 1, "apb answer");
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge clk);
   endtask : apb

   // take n pixels from the stream into px
   task grab(input int n);
      int k;
      for (int i = 0; i < n; i++) begin
         k = 0;
         do begin
            @(negedge clk);
            k++;
         end while (pix_valid !== 1'b1 && k < 50);
         cmp(k < 50, 1, "pixel wait");
         px[i] = pix;
         @(posedge clk);
      end
   endtask : grab

   // stop, drain the buffer, then start with new settings
   task run(input logic [7:0] ctl, input logic [4:0] cfg);
      apb(1'b1, 12'h190, 32'h10);
      repeat (40) @(posedge clk);
      apb(1'b1, 12'h194, {27'h0, cfg});
      apb(1'b1, 12'h190, {24'h0, ctl | 8'h01});
   endtask : run

   task t_reset;
      apb(1'b0, 12'h190, 0);
      cmp(rd, 32'h10, "control reset");
      cmp(pix_valid, 0, "idle after reset");
      apb(1'b0, 12'h194, 0);
      cmp(rd, 32'h0, "config reset");
      apb(1'b0, 12'h1D0, 0);
      cmp(rd, 32'h10, "status reset");
   endtask : t_reset

   task t_regs;
      apb(1'b1, 12'h18C, 32'h1);
      cmp(pwdn, 1, "powerdown bit");
      apb(1'b0, 12'h3FC, 0);
      cmp(er, 1, "unmapped error");
      cmp(rd, 32'h0, "unmapped read");
      apb(1'b1, 12'h191, 32'hFF);
      cmp(er, 1, "misaligned write");
      apb(1'b1, 12'h1D0, 32'hFF);
      cmp(er, 0, "status write");
   endtask : t_regs

   task t_solid;
      for (int v = 0; v < 2; v++) begin
         for (int c = 1; c < 6; c++) begin
            run({c[3:0], 4'h0}, {3'h0, v[0], 1'b0});
            grab(1);
            cmp(px[0][23:0], sol[c-1] ^ {24{v[0]}}, "solid");
            cmp(px[0][25], 1, "frame start");
         end
      end
      apb(1'b1, 12'h1C0, 32'h12);
      apb(1'b1, 12'h1C4, 32'h34);
      apb(1'b1, 12'h1C8, 32'h56);
      run(8'hE0, 5'h0);
      grab(1);
      cmp(px[0][23:0], 24'h123456, "custom");
   endtask : t_solid

   task t_ramp;
      run(8'h60, 5'h0);
      grab(65);
      cmp(px[1][23:0], 24'h040404, "hramp step");
      cmp(px[63][24:0], 25'h1FCFCFC, "hramp end");
      cmp(px[64][23:0], 24'h0, "hramp next row");
      run(8'h90, 5'h0);
      grab(64);
      cmp(px[63][23:0], 24'h0000FC, "blue hramp");
      run(8'hA0, 5'h0);
      grab(65);
      cmp(px[63][23:0], 24'h0, "vramp row0");
      cmp(px[64][23:0], 24'h080808, "vramp row1");
      run(8'hD0, 5'h2);
      grab(65);
      cmp(px[64][23:0], 24'hFFFFF7, "inverted blue vramp");
   endtask : t_ramp

   task t_bars;
      run(8'h14, 5'h0);
      grab(64);
      for (int j = 0; j < 8; j++) begin
         cmp(px[8*j][23:0], bar[j], "bar");
      end
      for (int r = 0; r < 2; r++) begin
         run({6'h07, r[0], 1'b0}, 5'h0);
         grab(64);
         for (int j = 0; j < 4; j++) begin
            cmp(px[16*j][23:0], vc[4*r+j], "vcom band");
         end
      end
      apb(1'b0, 12'h1D0, 0);
      cmp(rd[2:0], 3'h5, "status mode");
   endtask : t_bars

   task t_scroll;
      apb(1'b1, 12'h190, 32'h30);
      apb(1'b1, 12'h194, 32'h1);
      apb(1'b1, 12'h190, 32'h50);
      apb(1'b0, 12'h1D0, 0);
      cmp(rd[7:4], 4'h3, "selector ignored");
      apb(1'b1, 12'h194, 32'h0);
      apb(1'b0, 12'h1D0, 0);
      cmp(rd[7:4], 4'h5, "selector followed");
      apb(1'b1, 12'h1CC, 32'h2);
      apb(1'b1, 12'h194, 32'h1);
      apb(1'b1, 12'h190, 32'h51);
      repeat (2100) @(posedge clk);
      apb(1'b0, 12'h1D0, 0);
      cmp(rd[7:4], 4'h5, "held before frame time");
      repeat (2048) @(posedge clk);
      apb(1'b0, 12'h1D0, 0);
      cmp(rd[7:4], 4'h6, "scrolled after frame time");
   endtask : t_scroll

   task t_stall;
      run(8'h60, 5'h0);
      grab(2);
      pix_ready <= 1'b0;
      repeat (40) @(posedge clk);
      cmp({pix_valid, pix[23:0]}, 25'h1080808, "held while stalled");
      pix_ready <= 1'b1;
      grab(3);
      for (int j = 0; j < 3; j++) begin
         cmp(px[j][23:0], {3{6'(j + 2), 2'b00}}, "no pixel lost");
      end
   endtask : t_stall

   // main sequence
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pix_ready = 1'b1;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_regs();
      t_solid();
      t_ramp();
      t_bars();
      t_scroll();
      t_stall();
      finish_test();
   end

   // watchdog against a hang
   initial begin
      #3000000;
      err_total++;
      $display("CHECK FAILED %0t watchdog expired", $time);
      finish_test();
   end
endmodule : vtp_top_tb
`default_nettype wire
